// ===== verilog/ultrasonic_teach_controller.sv
// teach sequencing, button lock and error signalling for the sensor
`timescale 1ns/1ns
module ultrasonic_teach_controller #(
  parameter int unsigned MS_CYCLES = teach_pkg::MS_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        button2_i,
  input  wire logic        teach_pin_i,
  input  wire logic        pin_reconf_i,
  input  wire logic        long_range_i,
  input  wire logic [10:0] distance_i,
  input  wire logic        distance_valid_i,
  input  wire logic        switching_output_i,
  output logic             led_yellow_o,
  output logic             led_green_o,
  output logic             teach_active_o,
  output logic             teach_error_o,
  output logic             rising_o,
  output logic [10:0]      range_lo_o,
  output logic [10:0]      range_hi_o,
  output logic [1:0]       analog_output_err_o,
  output logic [10:0]      window_lo_o,
  output logic [10:0]      window_hi_o,
  output logic             window_load_o,
  output logic [10:0]      switch_point_o,
  output logic             switch_load_o
);

  // ****************************************
  // state
  // ****************************************
  teach_pkg::state_t st_q, st_d;
  logic [16:0] div_q, div_d;
  logic        tick_q, tick_d;
  logic [13:0] hold_q, hold_d;
  logic [13:0] pcnt_q, pcnt_d;
  logic        pprev_q, pprev_d;
  logic        src_pin_q, src_pin_d;
  logic [10:0] first_q, first_d;
  logic [13:0] tph_cnt_q, tph_cnt_d;
  logic [13:0] eph_cnt_q, eph_cnt_d;
  logic        tph_q, tph_d;
  logic        eph_q, eph_d;
  logic        err_q, err_d;
  logic        rise_q, rise_d;
  logic [10:0] lo_q, lo_d;
  logic [10:0] hi_q, hi_d;
  logic [1:0]  aerr_q, aerr_d;
  logic [10:0] wlo_q, wlo_d;
  logic [10:0] whi_q, whi_d;
  logic        wld_q, wld_d;
  logic [10:0] sp_q, sp_d;
  logic        sld_q, sld_d;
  logic        ly_q, ly_d;
  logic        lg_q, lg_d;
  logic        busy_q, busy_d;

  logic        pin_teach;
  logic        btn;
  logic        fall;
  logic        one_pt;
  logic        two_pt;
  logic [10:0] smin;
  logic [10:0] smax;
  logic [10:0] gap;
  logic [10:0] plo;
  logic [10:0] phi;
  logic        bad;
  logic        in_scan;
  logic        finish;

  // ****************************************
  // next values
  // ****************************************
  always_comb begin
    st_d      = st_q;
    div_d     = div_q;
    tick_d    = 1'b0;
    hold_d    = hold_q;
    pcnt_d    = pcnt_q;
    pprev_d   = teach_pin_i;
    src_pin_d = src_pin_q;
    first_d   = first_q;
    tph_cnt_d = tph_cnt_q;
    eph_cnt_d = eph_cnt_q;
    tph_d     = tph_q;
    eph_d     = eph_q;
    err_d     = err_q;
    rise_d    = rise_q;
    lo_d      = lo_q;
    hi_d      = hi_q;
    aerr_d    = aerr_q;
    wlo_d     = wlo_q;
    whi_d     = whi_q;
    wld_d     = 1'b0;
    sp_d      = sp_q;
    sld_d     = 1'b0;
    finish    = 1'b0;

    // 1 ms enable; the divider is a parameter so a bench can shorten it
    if (div_q == 17'(MS_CYCLES - 1)) begin
      div_d  = '0;
      tick_d = 1'b1;
    end else begin
      div_d = div_q + 17'h00001;
    end

    // free running flash phases for both rates
    if (tick_q) begin
      if (tph_cnt_q == 14'(teach_pkg::TEACH_HALF - 1)) begin
        tph_cnt_d = '0;
        tph_d     = ~tph_q;
      end else begin
        tph_cnt_d = tph_cnt_q + 14'h0001;
      end
      if (eph_cnt_q == 14'(teach_pkg::ERR_HALF - 1)) begin
        eph_cnt_d = '0;
        eph_d     = ~eph_q;
      end else begin
        eph_cnt_d = eph_cnt_q + 14'h0001;
      end
    end

    pin_teach = ~pin_reconf_i;
    // while pin_reconf_i is low, a high pin locks the buttons for as long as it stays high
    btn = button2_i & ~(pin_teach & teach_pin_i);

    // pin pulse width in ms; saturates so a lock never looks like a pulse
    if (teach_pin_i) begin
      if (!pprev_q) begin
        pcnt_d = '0;
      end else if (tick_q && pcnt_q != 14'(teach_pkg::LOCK_MS)) begin
        pcnt_d = pcnt_q + 14'h0001;
      end
    end
    fall   = pin_teach & pprev_q & ~teach_pin_i;
    one_pt = fall && pcnt_q >= 14'(teach_pkg::PIN1_MIN_MS)
                  && pcnt_q <= 14'(teach_pkg::PIN1_MAX_MS);
    two_pt = fall && pcnt_q >= 14'(teach_pkg::PIN2_MIN_MS)
                  && pcnt_q <= 14'(teach_pkg::PIN2_MAX_MS);

    // scan limits and least spacing per variant
    smin = long_range_i ? teach_pkg::SCAN_LO_L : teach_pkg::SCAN_LO_S;
    smax = long_range_i ? teach_pkg::SCAN_HI_L : teach_pkg::SCAN_HI_S;
    gap  = long_range_i ? teach_pkg::GAP_L : teach_pkg::GAP_S;
    in_scan = distance_i >= smin && distance_i <= smax;

    // ordered pair of first point and live distance
    plo = (first_q < distance_i) ? first_q : distance_i;
    phi = (first_q < distance_i) ? distance_i : first_q;
    bad = plo < smin || phi > smax || (phi - plo) < gap;

    unique case (st_q)
      teach_pkg::S_IDLE: begin
        if (btn) begin
          hold_d = '0;
          st_d   = teach_pkg::S_HOLD;
        end else if (two_pt) begin
          first_d   = distance_i;
          src_pin_d = 1'b1;
          st_d      = teach_pkg::S_WAIT;
        end else if (one_pt) begin
          // static single point of the switching output
          if (in_scan) begin
            sp_d  = distance_i;
            sld_d = 1'b1;
            err_d = 1'b0;
          end else begin
            err_d = 1'b1;
          end
        end
      end
      teach_pkg::S_HOLD: begin
        if (!btn) begin
          st_d = teach_pkg::S_IDLE;
        end else if (tick_q) begin
          hold_d = hold_q + 14'h0001;
          if (hold_q == 14'(teach_pkg::HOLD_MIN_MS - 1)) begin
            first_d = distance_i;
            st_d    = teach_pkg::S_ARMED;
          end
        end
      end
      teach_pkg::S_ARMED: begin
        if (!btn) begin
          src_pin_d = 1'b0;
          st_d      = teach_pkg::S_WAIT;
        end else if (tick_q) begin
          hold_d = hold_q + 14'h0001;
          // held past the window: the teach is dropped
          if (hold_q == 14'(teach_pkg::HOLD_MAX_MS - 1)) begin
            st_d = teach_pkg::S_IDLE;
          end
        end
      end
      teach_pkg::S_WAIT: begin
        if (src_pin_q) begin
          finish = two_pt;
        end else if (btn) begin
          hold_d = '0;
          st_d   = teach_pkg::S_PRESS;
        end
      end
      teach_pkg::S_PRESS: begin
        if (!btn) begin
          if (hold_q < 14'(teach_pkg::SHORT_MS)) begin
            finish = 1'b1;
          end else begin
            st_d = teach_pkg::S_WAIT;
          end
        end else if (tick_q && hold_q != 14'(teach_pkg::SHORT_MS)) begin
          hold_d = hold_q + 14'h0001;
        end
      end
    endcase

    if (finish) begin
      st_d = teach_pkg::S_IDLE;
      if (bad) begin
        err_d = 1'b1;
      end else begin
        err_d = 1'b0;
        lo_d  = plo;
        hi_d  = phi;
        if (src_pin_q) begin
          // window and range move together; direction is kept
          wlo_d = plo;
          whi_d = phi;
          wld_d = 1'b1;
        end else begin
          rise_d = first_q < distance_i;
        end
      end
    end

    // too close and too far are measured in distance, not output sense
    if (distance_valid_i) begin
      if (distance_i < lo_q) begin
        aerr_d = teach_pkg::AERR_CLOSE;
      end else if (distance_i > hi_q) begin
        aerr_d = teach_pkg::AERR_FAR;
      end else begin
        aerr_d = teach_pkg::AERR_NONE;
      end
    end

    // registered copy so the busy flag leaves the block from a flop
    busy_d = st_d != teach_pkg::S_IDLE;

    // teach flashing outranks error flashing, which outranks measurement
    if (st_d == teach_pkg::S_ARMED || st_d == teach_pkg::S_WAIT
        || st_d == teach_pkg::S_PRESS) begin
      ly_d = tph_q;
      lg_d = ~tph_q;
    end else if (err_d) begin
      ly_d = eph_q;
      lg_d = eph_q;
    end else begin
      ly_d = switching_output_i;
      lg_d = in_scan;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_q      <= teach_pkg::S_IDLE;
      div_q     <= '0;
      tick_q    <= 1'b0;
      hold_q    <= '0;
      pcnt_q    <= '0;
      pprev_q   <= 1'b0;
      src_pin_q <= 1'b0;
      first_q   <= '0;
      tph_cnt_q <= '0;
      eph_cnt_q <= '0;
      tph_q     <= 1'b0;
      eph_q     <= 1'b0;
      err_q     <= 1'b0;
      rise_q    <= teach_pkg::RISING_RST;
      lo_q      <= teach_pkg::SCAN_LO_S;
      hi_q      <= teach_pkg::SCAN_HI_S;
      aerr_q    <= teach_pkg::AERR_NONE;
      wlo_q     <= teach_pkg::SCAN_LO_S;
      whi_q     <= teach_pkg::SCAN_HI_S;
      wld_q     <= 1'b0;
      sp_q      <= teach_pkg::SCAN_HI_S;
      sld_q     <= 1'b0;
      ly_q      <= 1'b0;
      lg_q      <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      div_q     <= div_d;
      tick_q    <= tick_d;
      hold_q    <= hold_d;
      pcnt_q    <= pcnt_d;
      pprev_q   <= pprev_d;
      src_pin_q <= src_pin_d;
      first_q   <= first_d;
      tph_cnt_q <= tph_cnt_d;
      eph_cnt_q <= eph_cnt_d;
      tph_q     <= tph_d;
      eph_q     <= eph_d;
      err_q     <= err_d;
      rise_q    <= rise_d;
      lo_q      <= lo_d;
      hi_q      <= hi_d;
      aerr_q    <= aerr_d;
      wlo_q     <= wlo_d;
      whi_q     <= whi_d;
      wld_q     <= wld_d;
      sp_q      <= sp_d;
      sld_q     <= sld_d;
      ly_q      <= ly_d;
      lg_q      <= lg_d;
      busy_q    <= busy_d;
    end
  end

  assign led_yellow_o        = ly_q;
  assign led_green_o         = lg_q;
  assign teach_active_o      = busy_q;
  assign teach_error_o       = err_q;
  assign rising_o            = rise_q;
  assign range_lo_o          = lo_q;
  assign range_hi_o          = hi_q;
  assign analog_output_err_o = aerr_q;
  assign window_lo_o         = wlo_q;
  assign window_hi_o         = whi_q;
  assign window_load_o       = wld_q;
  assign switch_point_o      = sp_q;
  assign switch_load_o       = sld_q;

endmodule

// ===== verilog/teach_pkg.sv
// constants and types for the teach and lock controller
package teach_pkg;
  // ****************************************
  // clock and time base
  // ****************************************
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned MS_CYCLES   = CLK_HZ / MS_PER_S;
  localparam int unsigned DIV_W       = 17;
  localparam int unsigned CNT_W       = 14;
  localparam int unsigned DIST_W      = 11;
  // ****************************************
  // button and pin timing in ms, flash rates in Hz
  // ****************************************
  localparam int unsigned HOLD_MIN_MS = 7000;
  localparam int unsigned HOLD_MAX_MS = 12000;
  localparam int unsigned SHORT_MS    = 2000;
  localparam int unsigned PIN1_MIN_MS = 20;
  localparam int unsigned PIN1_MAX_MS = 80;
  localparam int unsigned PIN2_MIN_MS = 120;
  localparam int unsigned PIN2_MAX_MS = 180;
  localparam int unsigned LOCK_MS     = 1000;
  localparam int unsigned TEACH_HZ    = 3;
  localparam int unsigned ERR_HZ      = 8;
  localparam int unsigned TEACH_HALF  = MS_PER_S / (2 * TEACH_HZ);
  localparam int unsigned ERR_HALF    = MS_PER_S / (2 * ERR_HZ);
  // ****************************************
  // distances in mm and reset direction
  // ****************************************
  localparam logic [10:0] SCAN_LO_S   = 11'h019;
  localparam logic [10:0] SCAN_HI_S   = 11'h190;
  localparam logic [10:0] SCAN_LO_L   = 11'h096;
  localparam logic [10:0] SCAN_HI_L   = 11'h514;
  localparam logic [10:0] GAP_S       = 11'h028;
  localparam logic [10:0] GAP_L       = 11'h082;
  localparam logic        RISING_RST  = 1'b1;
  // ****************************************
  // analog error codes and states
  // ****************************************
  localparam logic [1:0]  AERR_NONE   = 2'h0;
  localparam logic [1:0]  AERR_CLOSE  = 2'h1;
  localparam logic [1:0]  AERR_FAR    = 2'h2;
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_HOLD  = 5'h02,
    S_ARMED = 5'h04,
    S_WAIT  = 5'h08,
    S_PRESS = 5'h10
  } state_t;
endpackage

// ===== tb/operator_model.sv
// operator model: button 2 and the multi-function teach line
`timescale 1ns/1ns
module operator_model #(
  parameter int unsigned MS = 2
) (
  input  wire logic clock_i,
  output logic      button2_o,
  output logic      teach_pin_o
);
  // an unconnected line reads low, so both rest low
  initial begin
    button2_o   = 1'b0;
    teach_pin_o = 1'b0;
  end
  task automatic level(input logic pin, input logic val);
    @(posedge clock_i);
    if (pin) begin
      teach_pin_o <= val;
    end else begin
      button2_o <= val;
    end
  endtask
  // press or pulse for a number of ms
  task automatic drive(input logic pin, input int unsigned ms);
    level(pin, 1'b1);
    repeat (ms * MS) @(posedge clock_i);
    level(pin, 1'b0);
  endtask
endmodule

// ===== tb/teach_properties.sv
// assertion checker for the teach and lock controller
`timescale 1ns/1ns
module teach_properties #(
  parameter int unsigned MS_CYCLES = teach_pkg::MS_CYCLES
) (
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        teach_pin_i,
  input wire logic        pin_reconf_i,
  input wire logic        long_range_i,
  input wire logic [10:0] distance_i,
  input wire logic        distance_valid_i,
  input wire logic        switching_output_i,
  input wire logic        led_yellow_o,
  input wire logic        led_green_o,
  input wire logic        teach_active_o,
  input wire logic        teach_error_o,
  input wire logic        rising_o,
  input wire logic [10:0] range_lo_o,
  input wire logic [10:0] range_hi_o,
  input wire logic [1:0]  analog_output_err_o,
  input wire logic [10:0] window_lo_o,
  input wire logic [10:0] window_hi_o,
  input wire logic        window_load_o,
  input wire logic        switch_load_o
);
  // ****
  // helpers
  // ****
  localparam int unsigned ERR_T = (teach_pkg::ERR_HALF + 2) * MS_CYCLES;
  logic        err_mode;
  logic        yel_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [1:0]  exp_err;
  assign err_mode = teach_error_o && !teach_active_o;
  assign exp_err  = (distance_i < range_lo_o) ? teach_pkg::AERR_CLOSE :
                    (distance_i > range_hi_o) ? teach_pkg::AERR_FAR : teach_pkg::AERR_NONE;
  // restart on each yellow edge so one half period is measured
  always_comb begin
    cnt_d = (err_mode && led_yellow_o == yel_q) ? cnt_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clock_i) begin
    yel_q <= led_yellow_o;
    cnt_q <= nrst_i ? cnt_d : 16'h0000;
  end
  default clocking dc @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  property p_lock;
    teach_pin_i && !pin_reconf_i && !teach_active_o |=> !teach_active_o;
  endproperty
  a_lock: assert property (p_lock) else $error("button acted while locked");
  property p_err_leds;
    err_mode && $past(err_mode) |-> led_yellow_o == led_green_o;
  endproperty
  a_err_leds: assert property (p_err_leds) else $error("error flash out of phase");
  property p_err_rate;
    err_mode |-> cnt_q < ERR_T;
  endproperty
  a_err_rate: assert property (p_err_rate) else $error("error flash too slow");
  property p_analog;
    distance_valid_i && !teach_active_o |=> analog_output_err_o == $past(exp_err);
  endproperty
  a_analog: assert property (p_analog) else $error("analog error level wrong");
  property p_gap;
    !teach_error_o && !teach_active_o |->
      range_hi_o - range_lo_o >= (long_range_i ? teach_pkg::GAP_L : teach_pkg::GAP_S);
  endproperty
  a_gap: assert property (p_gap) else $error("range points too close");
  property p_dir_kept;
    window_load_o |-> $stable(rising_o);
  endproperty
  a_dir_kept: assert property (p_dir_kept) else $error("pin changed direction");
  property p_window;
    window_load_o |-> window_lo_o == range_lo_o && window_hi_o == range_hi_o;
  endproperty
  a_window: assert property (p_window) else $error("window and range differ");
  property p_meas_led;
    !teach_active_o && !teach_error_o ##1 !teach_active_o && !teach_error_o
      |-> led_yellow_o == $past(switching_output_i);
  endproperty
  a_meas_led: assert property (p_meas_led) else $error("yellow not switching state");
  c_window: cover property (window_load_o);
  c_switch: cover property (switch_load_o);
  c_err: cover property (err_mode && $rose(led_yellow_o));
endmodule
bind ultrasonic_teach_controller teach_properties #(.MS_CYCLES(MS_CYCLES)) u_props (
  .clock_i, .nrst_i, .teach_pin_i, .pin_reconf_i, .long_range_i, .distance_i,
  .distance_valid_i, .switching_output_i, .led_yellow_o, .led_green_o, .teach_active_o,
  .teach_error_o, .rising_o, .range_lo_o, .range_hi_o, .analog_output_err_o,
  .window_lo_o, .window_hi_o, .window_load_o, .switch_load_o
);

// ===== tb/tb_top.sv
// self-checking bench for the teach and lock controller
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned MS = 2;
  logic        clock_i, nrst_i, button2_i, teach_pin_i, pin_reconf_i, long_range_i;
  logic        distance_valid_i, switching_output_i, led_yellow_o, led_green_o;
  logic        teach_active_o, teach_error_o, rising_o, window_load_o, switch_load_o, act_q;
  logic [10:0] distance_i, range_lo_o, range_hi_o, window_lo_o, window_hi_o, switch_point_o;
  logic [1:0]  analog_output_err_o;
  logic [33:0] eq[$];
  logic [10:0] sq[$];
  logic [10:0] ad[3] = '{11'h032, 11'h0C8, 11'h15E};
  logic [1:0]  ac[3] = '{teach_pkg::AERR_CLOSE, teach_pkg::AERR_NONE, teach_pkg::AERR_FAR};
  int          n_mismatch, checks_done, seed, rnd;
  ultrasonic_teach_controller #(.MS_CYCLES(MS)) dut (
    .clock_i, .nrst_i, .button2_i, .teach_pin_i, .pin_reconf_i, .long_range_i, .distance_i,
    .distance_valid_i, .switching_output_i, .led_yellow_o, .led_green_o, .teach_active_o,
    .teach_error_o, .rising_o, .range_lo_o, .range_hi_o, .analog_output_err_o, .window_lo_o,
    .window_hi_o, .window_load_o, .switch_point_o, .switch_load_o
  );
  operator_model #(.MS(MS)) op (.clock_i, .button2_o(button2_i), .teach_pin_o(teach_pin_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic cmp(input string name, input logic [33:0] exp, input logic [33:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    while ((teach_active_o !== 1'b0 || eq.size() != 0 || sq.size() != 0) && i < 4000) begin
      @(negedge clock_i);
      i++;
    end
    if (i >= 4000) begin
      n_mismatch++;
      end_sim();
    end
    repeat (4) @(posedge clock_i);
  endtask
  task automatic bteach(input logic [10:0] a, input logic [10:0] b, input logic [33:0] e);
    distance_i <= a;
    op.drive(1'b0, 7500);
    distance_i <= b;
    eq.push_back(e);
    op.drive(1'b0, 100);
    wait_idle();
  endtask
  // ****
  // watchers: oldest note against each result
  // ****
  always @(negedge clock_i) begin
    if (act_q === 1'b1 && teach_active_o === 1'b0) begin
      cmp("teach_result", eq.size() != 0 ? eq.pop_front() : 'x,
          {teach_error_o, rising_o, range_lo_o, range_hi_o});
    end
    if (switch_load_o === 1'b1) begin
      cmp("switch_point", sq.size() != 0 ? {23'h0, sq.pop_front()} : 'x,
          {23'h0, switch_point_o});
    end
    act_q = teach_active_o;
  end
  always @(posedge clock_i) begin
    rnd = $random(seed);
    switching_output_i <= rnd[0];
  end
  initial begin
    seed = 88;
    n_mismatch = 0;
    checks_done = 0;
    act_q = 1'b0;
    nrst_i = 1'b0;
    pin_reconf_i = 1'b0;
    long_range_i = 1'b0;
    distance_i = 11'h064;
    distance_valid_i = 1'b0;
    switching_output_i = 1'b0;
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    op.level(1'b1, 1'b1);
    fork
      op.drive(1'b0, 200);
      begin
        repeat (100 * MS) @(negedge clock_i);
        cmp("locked_active", 34'h0, {33'h0, teach_active_o});
      end
    join
    repeat (1000 * MS) @(posedge clock_i);
    op.level(1'b1, 1'b0);
    wait_idle();
    bteach(11'h064, 11'h12C, {2'b01, 11'h064, 11'h12C});
    for (int i = 0; i < 3; i++) begin
      distance_i <= ad[i];
      distance_valid_i <= 1'b1;
      @(posedge clock_i);
      distance_valid_i <= 1'b0;
      @(negedge clock_i);
      cmp("analog_err", {32'h0, ac[i]}, {32'h0, analog_output_err_o});
    end
    bteach(11'h15E, 11'h0C8, {2'b00, 11'h0C8, 11'h15E});
    // long variant: 120 mm apart is 10 mm short of the 130 mm limit
    long_range_i <= 1'b1;
    bteach(11'h0C8, 11'h140, {2'b10, 11'h0C8, 11'h15E});
    repeat (300 * MS) @(posedge clock_i);
    long_range_i <= 1'b0;
    distance_i <= 11'h03C;
    eq.push_back({2'b00, 11'h03C, 11'h104});
    op.drive(1'b1, 150);
    repeat (50 * MS) @(posedge clock_i);
    distance_i <= 11'h104;
    op.drive(1'b1, 150);
    wait_idle();
    for (int i = 0; i < 3; i++) begin
      rnd = $random(seed);
      sq.push_back(11'(25 + ($unsigned(rnd) % 376)));
      distance_i <= sq[sq.size() - 1];
      op.drive(1'b1, 50);
      wait_idle();
    end
    // reconfigured pin must not teach: any load finds no note
    pin_reconf_i <= 1'b1;
    op.drive(1'b1, 50);
    wait_idle();
    end_sim();
  end
endmodule
